// ---- common/ivr_defs.vh ----
// constants for the interrupt vector resolver
// assumes a 20-bit address space and APB word addressing
`ifndef IVR_DEFS_VH
`define IVR_DEFS_VH
// fixed vector entries
`define IVR_FIX_LOW    20'hFFFDC
`define IVR_FIX_HIGH   20'hFFFFF
`define IVR_FIX_UND    20'hFFFDC
`define IVR_FIX_OVF    20'hFFFE0
`define IVR_FIX_BRK    20'hFFFE4
`define IVR_FIX_AMATCH 20'hFFFE8
`define IVR_FIX_STEP   20'hFFFEC
`define IVR_FIX_WDOG   20'hFFFF0
`define IVR_FIX_DBG    20'hFFFF4
`define IVR_FIX_NMI    20'hFFFF8
`define IVR_FIX_RESET  20'hFFFFC
`define IVR_BRK_REDIR  8'hFF
// variable table: 256 bytes, 4 bytes per slot
`define IVR_TABLE_BYTES 9'h100
`define IVR_SLOT_BRK    6'h00
`define IVR_LAST_PERIPH 6'h1F
// register indices, byte address = 4 * index
`define IVR_IDX_FLAG  12'h010
`define IVR_IDX_BASE  12'h011
`define IVR_IDX_DCFG  12'h012
`define IVR_IDX_STAT  12'h013
`define IVR_IDX_CTRL0 12'h040
`define IVR_IDX_CAUSE 12'h35F
// fields
`define IVR_FLAG_IEN  0
`define IVR_FLAG_IPLL 4
`define IVR_CTRL_REQ  3
`define IVR_DCFG_AMEN 0
`define IVR_DCFG_I2C  1
`define IVR_CAUSE_S8  6
`define IVR_CAUSE_S9  7
// non-maskable pending bits, lowest index wins
`define IVR_NM_RESET 0
`define IVR_NM_WDOG  1
`define IVR_NM_NMI   2
`define IVR_NM_DBG   3
`define IVR_NM_STEP  4
`define IVR_NM_AMAT  5
`define IVR_NM_UND   6
`define IVR_NM_OVF   7
`define IVR_NM_BRK   8
`define IVR_NM_SWI   9
`define IVR_NM_COUNT 10
`endif

// ---- rtl/ivr_core.v ----
// interrupt vector resolver: source state, priority gating, vector address
// assumes an APB master on clk_sys and a CPU sequencer that acks vectors
//
// Notes on behaviour
// - fixed 4-byte vectors span FFFDC..FFFFF
// - undefined opcode uses entry FFFDC
// - overflow trap uses entry FFFE0
// - break uses FFFE4, FF redirects slot 0
// - address match uses FFFE8, needs enable
// - step FFFEC, debugger FFFF4, debug only
// - NMI pin uses entry FFFF8
// - variable table 256 bytes at base
// - slot n sits at base plus 4n
// - slot zero is break, unmaskable
// - pin irqs at slots 4, 29-31
// - type-B timers at slots 5-7, 26-28
// - type-A timers at slots 21-25
// - async serial at slots 17-20
// - slots 15/16 carry NACK/ACK in I2C
// - slots 8/9 picked by cause bits 6,7
// - slots 10-14 collision, DMA, key, A-D
// - slots 32-63 software only, unmaskable
// - per-source request and level, flag word
// - request bit: write 0 clears only
// - gating applies to maskable sources only
// - accept: enable, request, level above PROCESSOR_PRIORITY_LEVEL
// - level 0 off, 7 highest
// - hardware sets, accept clears request bit
// - global enable resets to zero
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
`include "ivr_defs.vh"
module ivr_core (
  // clock, reset, enable
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        ce,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // peripheral request pulses, index is slot
  input  wire [31:0] periphEvt,
  input  wire        clockedSerialBEvt,
  input  wire        clockedSerialAEvt,
  input  wire        i2cNackEvt,
  input  wire        i2cAckEvt,
  // special sources
  input  wire        nmiPinN,
  input  wire        watchdogEvt,
  input  wire        addrMatchEvt,
  input  wire        singleStepEvt,
  input  wire        debuggerBreakEvt,
  // cpu instruction traps
  input  wire        undefOpcodeEvt,
  input  wire        overflowTrapEvt,
  input  wire        breakInstrEvt,
  input  wire [7:0]  breakFixedByte,
  input  wire        softIntEvt,
  input  wire [5:0]  softIntNum,
  // vector to cpu sequencer
  output reg         vecValid,
  output reg  [19:0] vecAddr,
  output reg  [5:0]  vecNum,
  output reg  [2:0]  vecLevel,
  output reg         vecMaskable,
  input  wire        vecAck
);

// ==========================================================
// state
wire [95:0] ctrlLevelFlat;
wire [31:0] ctrlReq;
reg        flagIen;
reg [2:0]  flagIpl;
reg [19:0] tableBase;
reg        amatchEn;
reg        i2cMode;
reg [1:0]  causeSel;
reg [`IVR_NM_COUNT-1:0] nmPend;
reg [5:0]  swNum;
reg        ackHold;
reg        accDone;
reg [3:0]  vecKind;
reg        nmiSync1;
reg        nmiSync2;
reg        nmiLast;

// ==========================================================
// apb decode; one wait state so read data comes from a flop
wire [11:0] wIdx     = paddr[13:2];
wire        access   = psel & penable;
wire        doIt     = access & accDone;
wire        isCtrl   = (wIdx >= `IVR_IDX_CTRL0) && (wIdx < `IVR_IDX_CTRL0 + 12'h020);
wire [4:0]  ctrlN    = wIdx[4:0];
wire        mapped   = isCtrl || wIdx == `IVR_IDX_FLAG || wIdx == `IVR_IDX_BASE ||
                       wIdx == `IVR_IDX_DCFG || wIdx == `IVR_IDX_STAT ||
                       wIdx == `IVR_IDX_CAUSE;
wire        wrStb    = doIt & pwrite & mapped;
// a frozen cycle must not complete a transfer the registers did not take
assign pready  = doIt & ce;
assign pslverr = doIt & ce & ~mapped;

always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    accDone <= 1'b0;
  end else if (ce) begin
    accDone <= access & ~accDone;
  end
end

always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    prdata <= 32'h00000000;
  end else if (ce && access && !accDone) begin
    prdata <= 32'h00000000;
    if (isCtrl) begin
      prdata[2:0]           <= ctrlLevelFlat[3*ctrlN +: 3];
      prdata[`IVR_CTRL_REQ] <= ctrlReq[ctrlN];
    end else if (wIdx == `IVR_IDX_FLAG) begin
      prdata[`IVR_FLAG_IEN]                  <= flagIen;
      prdata[`IVR_FLAG_IPLL+2:`IVR_FLAG_IPLL] <= flagIpl;
    end else if (wIdx == `IVR_IDX_BASE) begin
      prdata[19:0] <= tableBase;
    end else if (wIdx == `IVR_IDX_DCFG) begin
      prdata[`IVR_DCFG_AMEN] <= amatchEn;
      prdata[`IVR_DCFG_I2C]  <= i2cMode;
    end else if (wIdx == `IVR_IDX_STAT) begin
      prdata[0]    <= vecValid;
      prdata[1]    <= vecMaskable;
      prdata[7:2]  <= vecNum;
      prdata[10:8] <= vecLevel;
    end else if (wIdx == `IVR_IDX_CAUSE) begin
      prdata[`IVR_CAUSE_S9:`IVR_CAUSE_S8] <= causeSel;
    end
  end
end

// ==========================================================
// configuration registers
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    flagIen   <= 1'b0;
    flagIpl   <= 3'h0;
    tableBase <= 20'h00000;
    amatchEn  <= 1'b0;
    i2cMode   <= 1'b0;
    causeSel  <= 2'h0;
  end else if (ce && wrStb) begin
    if (wIdx == `IVR_IDX_FLAG) begin
      flagIen <= pwdata[`IVR_FLAG_IEN];
      flagIpl <= pwdata[`IVR_FLAG_IPLL+2:`IVR_FLAG_IPLL];
    end
    if (wIdx == `IVR_IDX_BASE)
      tableBase <= pwdata[19:0];
    if (wIdx == `IVR_IDX_DCFG) begin
      amatchEn <= pwdata[`IVR_DCFG_AMEN];
      i2cMode  <= pwdata[`IVR_DCFG_I2C];
    end
    if (wIdx == `IVR_IDX_CAUSE)
      causeSel <= pwdata[`IVR_CAUSE_S9:`IVR_CAUSE_S8];
  end
end

// ==========================================================
// slot event routing
reg [31:0] slotEvt;
always @* begin
  slotEvt    = periphEvt;
  slotEvt[0] = 1'b0;
  slotEvt[8] = causeSel[0] ? periphEvt[8] : clockedSerialBEvt;
  slotEvt[9] = causeSel[1] ? periphEvt[9] : clockedSerialAEvt;
  slotEvt[15] = i2cMode ? i2cNackEvt : periphEvt[15];
  slotEvt[16] = i2cMode ? i2cAckEvt : periphEvt[16];
end

// ==========================================================
// per-source control; a new event beats a same-cycle clear
wire ackTake = vecValid & vecAck & ~ackHold;
genvar g;
generate
  for (g = 0; g < 32; g = g + 1) begin : gCtrl
    ivr_src_ctrl u_src (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .ce        (ce),
      .wrHit     (wrStb & isCtrl & (ctrlN == g)),
      .wrData    (pwdata[3:0]),
      .reqSet    (slotEvt[g]),
      .reqAccept (ackTake & vecMaskable & (vecNum == g)),
      .level     (ctrlLevelFlat[3*g +: 3]),
      .req       (ctrlReq[g])
    );
  end
endgenerate

// ==========================================================
// nmi pin synchroniser, falling edge
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    nmiSync1 <= 1'b1;
    nmiSync2 <= 1'b1;
    nmiLast  <= 1'b1;
  end else if (ce) begin
    nmiSync1 <= nmiPinN;
    nmiSync2 <= nmiSync1;
    nmiLast  <= nmiSync2;
  end
end
wire nmiFall = nmiLast & ~nmiSync2;

// ==========================================================
// non-maskable pending bits; set wins over the accept clear
reg [`IVR_NM_COUNT-1:0] nmSet;
always @* begin
  nmSet = {`IVR_NM_COUNT{1'b0}};
  nmSet[`IVR_NM_WDOG] = watchdogEvt;
  nmSet[`IVR_NM_NMI]  = nmiFall;
  nmSet[`IVR_NM_DBG]  = debuggerBreakEvt;
  nmSet[`IVR_NM_STEP] = singleStepEvt;
  nmSet[`IVR_NM_AMAT] = addrMatchEvt & amatchEn;
  nmSet[`IVR_NM_UND]  = undefOpcodeEvt;
  nmSet[`IVR_NM_OVF]  = overflowTrapEvt;
  nmSet[`IVR_NM_BRK]  = breakInstrEvt;
  nmSet[`IVR_NM_SWI]  = softIntEvt;
end

always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    nmPend <= 10'h001;
    swNum  <= 6'h00;
  end else if (ce) begin
    nmPend <= nmSet | (nmPend & ~((ackTake && !vecMaskable) ?
              (10'h001 << vecKind) : 10'h000));
    if (softIntEvt)
      swNum <= softIntNum;
  end
end

// ==========================================================
// resolution: fixed sources first, then best maskable level
reg [4:0]  bestN;
reg [2:0]  bestLvl;
reg        bestHit;
reg [3:0]  nmIdx;
reg        nmHit;
integer    i;
always @* begin
  bestN   = 5'h00;
  bestLvl = 3'h0;
  bestHit = 1'b0;
  for (i = 1; i < 32; i = i + 1) begin
    if (ctrlReq[i] && ctrlLevelFlat[3*i +: 3] > flagIpl && ctrlLevelFlat[3*i +: 3] > bestLvl) begin
      bestN   = i[4:0];
      bestLvl = ctrlLevelFlat[3*i +: 3];
      bestHit = 1'b1;
    end
  end
  bestHit = bestHit & flagIen;
  nmIdx = 4'h0;
  nmHit = 1'b0;
  for (i = `IVR_NM_COUNT - 1; i >= 0; i = i - 1) begin
    if (nmPend[i]) begin
      nmIdx = i[3:0];
      nmHit = 1'b1;
    end
  end
end

// variable slot address; offsets stay inside the 256-byte window
function [19:0] slotAddr;
  input [19:0] base;
  input [5:0]  n;
  begin
    slotAddr = base + {12'h000, n, 2'b00};
  end
endfunction

reg [19:0] nmAddr;
reg [5:0]  nmNum;
always @* begin
  nmNum = 6'h00;
  case (nmIdx)
    `IVR_NM_RESET: nmAddr = `IVR_FIX_RESET;
    `IVR_NM_WDOG:  nmAddr = `IVR_FIX_WDOG;
    `IVR_NM_NMI:   nmAddr = `IVR_FIX_NMI;
    `IVR_NM_DBG:   nmAddr = `IVR_FIX_DBG;
    `IVR_NM_STEP:  nmAddr = `IVR_FIX_STEP;
    `IVR_NM_AMAT:  nmAddr = `IVR_FIX_AMATCH;
    `IVR_NM_UND:   nmAddr = `IVR_FIX_UND;
    `IVR_NM_OVF:   nmAddr = `IVR_FIX_OVF;
    `IVR_NM_BRK: begin
      nmAddr = (breakFixedByte == `IVR_BRK_REDIR) ?
               slotAddr(tableBase, `IVR_SLOT_BRK) : `IVR_FIX_BRK;
    end
    `IVR_NM_SWI: begin
      nmAddr = slotAddr(tableBase, swNum);
      nmNum  = swNum;
    end
    default: nmAddr = `IVR_FIX_RESET;
  endcase
end

// ==========================================================
// vector register; re-resolved every cycle, paused one cycle after an
// accept so a stale choice is never offered twice
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    vecValid    <= 1'b0;
    vecAddr     <= 20'h00000;
    vecNum      <= 6'h00;
    vecLevel    <= 3'h0;
    vecMaskable <= 1'b0;
    vecKind     <= 4'h0;
    ackHold     <= 1'b0;
  end else if (ce) begin
    ackHold <= ackTake;
    if (ackTake || ackHold) begin
      vecValid <= 1'b0;
    end else if (nmHit) begin
      vecValid    <= 1'b1;
      vecAddr     <= nmAddr;
      vecNum      <= nmNum;
      vecLevel    <= 3'h0;
      vecMaskable <= 1'b0;
      vecKind     <= nmIdx;
    end else if (bestHit) begin
      vecValid    <= 1'b1;
      vecAddr     <= slotAddr(tableBase, {1'b0, bestN});
      vecNum      <= {1'b0, bestN};
      vecLevel    <= bestLvl;
      vecMaskable <= 1'b1;
      vecKind     <= 4'h0;
    end else begin
      vecValid <= 1'b0;
    end
  end
end

endmodule

// ==========================================================
// one source: priority level and request bit; the request bit sits
// just above the level field in the written word
module ivr_src_ctrl #(
  parameter LEVEL_W = 3
) (
  // clock, reset, enable
  input  wire               clk_sys,
  input  wire               resetn,
  input  wire               ce,
  // software write
  input  wire               wrHit,
  input  wire [LEVEL_W:0]   wrData,
  // hardware events
  input  wire               reqSet,
  input  wire               reqAccept,
  // state
  output reg  [LEVEL_W-1:0] level,
  output reg                req
);

always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    level <= {LEVEL_W{1'b0}};
    req   <= 1'b0;
  end else if (ce) begin
    if (wrHit)
      level <= wrData[LEVEL_W-1:0];
    if (reqSet)
      req <= 1'b1;
    else if (reqAccept)
      req <= 1'b0;
    else if (wrHit && !wrData[LEVEL_W])
      req <= 1'b0;
  end
end

endmodule

// ---- testbench/ivr_core_properties.sv ----
// checker for ivr_core: apb timing and vector resolution
// assumes ce is held high and the table base is word aligned
`timescale 1ns/1ns
module ivr_core_chk (
  // clock, reset
  input wire        clk_sys,
  input wire        resetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  // sources
  input wire        undefOpcodeEvt,
  input wire        overflowTrapEvt,
  input wire        watchdogEvt,
  input wire        debuggerBreakEvt,
  // vector
  input wire        vecValid,
  input wire [19:0] vecAddr,
  input wire [5:0]  vecNum,
  input wire [2:0]  vecLevel,
  input wire        vecMaskable,
  input wire        vecAck
);
  // ==========================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_one_wait: assert property (pready |-> psel && penable && $past(psel && penable)) else $error("no wait state");
  a_unmapped_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad refusal");
  a_reset_vector: assert property ($rose(resetn) |=> vecValid && vecAddr == 20'hFFFFC && !vecMaskable)
    else $error("reset vector missing");
  a_ack_gap: assert property (vecValid && vecAck |=> !vecValid [*2]) else $error("no gap after accept");
  a_nonmask_level: assert property (vecValid && !vecMaskable |-> vecLevel == 3'h0) else $error("level on nmi");
  a_mask_range: assert property (vecValid && vecMaskable |-> vecLevel != 3'h0 && vecNum inside {[1:31]})
    else $error("bad maskable vector");
  a_vec_align: assert property (vecValid |-> vecAddr[1:0] == 2'h0) else $error("vector not aligned");
  a_und_vector: assert property (undefOpcodeEvt && !vecValid |-> ##2 vecValid && vecAddr == 20'hFFFDC)
    else $error("undefined opcode vector");
  a_ovf_vector: assert property (overflowTrapEvt && !vecValid |-> ##2 vecValid && vecAddr == 20'hFFFE0)
    else $error("overflow vector");
  a_wdog_vector: assert property (watchdogEvt && !vecValid |-> ##2 vecValid && vecAddr == 20'hFFFF0)
    else $error("watchdog vector");
  a_dbg_vector: assert property (debuggerBreakEvt && !vecValid |-> ##2 vecValid && vecAddr == 20'hFFFF4)
    else $error("debugger vector");
endmodule
bind ivr_core ivr_core_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .undefOpcodeEvt(undefOpcodeEvt),
  .overflowTrapEvt(overflowTrapEvt), .watchdogEvt(watchdogEvt), .debuggerBreakEvt(debuggerBreakEvt),
  .vecValid(vecValid), .vecAddr(vecAddr), .vecNum(vecNum), .vecLevel(vecLevel),
  .vecMaskable(vecMaskable), .vecAck(vecAck));

// ---- testbench/ivr_cpu_seq.sv ----
// cpu sequencer model: accepts an offered vector after a set delay
// assumes vecValid comes from ivr_core on the same clock
`timescale 1ns/1ns
module ivr_cpu_seq (
  // clock, reset
  input wire       clk_sys,
  input wire       resetn,
  // vector handshake
  input wire       vecValid,
  input wire [3:0] ackDelay,
  output reg       vecAck
);
  // ==========================================
  // acceptance, one-cycle ack
  reg [3:0] waitCnt;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waitCnt <= 4'h0;
      vecAck <= 1'b0;
    end else if (vecValid && !vecAck) begin
      waitCnt <= waitCnt + 4'h1;
      vecAck <= (waitCnt >= ackDelay);
    end else begin
      waitCnt <= 4'h0;
      vecAck <= 1'b0;
    end
  end
endmodule

// ---- testbench/tb_ivr_core.sv ----
// testbench for ivr_core: register access over apb and vector resolution
// assumes the checker is bound and ivr_cpu_seq accepts the vectors
`timescale 1ns/1ns
`include "ivr_defs.vh"
module tb_ivr_core;
  // ==========================================
  // signals
  reg         clk_sys, resetn, psel, penable, pwrite, nmiPinN;
  reg  [13:0] paddr;
  reg  [31:0] pwdata, q;
  reg  [43:0] pulses;
  reg  [7:0]  breakFixedByte;
  reg  [5:0]  softIntNum;
  reg  [3:0]  ackDelay;
  wire        pready, pslverr, vecValid, vecMaskable, vecAck;
  wire [31:0] prdata;
  wire [19:0] vecAddr;
  wire [5:0]  vecNum;
  wire [2:0]  vecLevel;
  integer     n_fail, check_count, n, k;
  localparam [19:0] B1 = 20'h12340;
  localparam [19:0] B2 = 20'h0AB00;
  ivr_core DUT (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .periphEvt(pulses[43:12]), .clockedSerialBEvt(pulses[8]), .clockedSerialAEvt(pulses[9]),
    .i2cNackEvt(pulses[10]), .i2cAckEvt(pulses[11]), .nmiPinN(nmiPinN), .watchdogEvt(pulses[3]),
    .addrMatchEvt(pulses[4]), .singleStepEvt(pulses[5]), .debuggerBreakEvt(pulses[6]),
    .undefOpcodeEvt(pulses[0]), .overflowTrapEvt(pulses[1]), .breakInstrEvt(pulses[2]),
    .breakFixedByte(breakFixedByte), .softIntEvt(pulses[7]), .softIntNum(softIntNum),
    .vecValid(vecValid), .vecAddr(vecAddr), .vecNum(vecNum), .vecLevel(vecLevel),
    .vecMaskable(vecMaskable), .vecAck(vecAck));
  ivr_cpu_seq u_cpu (.clk_sys(clk_sys), .resetn(resetn), .vecValid(vecValid), .ackDelay(ackDelay),
    .vecAck(vecAck));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task apb(input [11:0] idx, input wr, input [31:0] wd);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [11:0] idx, input [31:0] exp);
    begin
      apb(idx, 1'b0, 32'h0);
      chk(q, exp);
    end
  endtask
  task expv(input [19:0] a, input m);
    begin
      k = 0;
      @(posedge clk_sys);
      while (!(vecValid === 1'b1 && vecAck === 1'b1) && k < 40) begin
        k = k + 1;
        @(posedge clk_sys);
      end
      chk({vecAck, vecMaskable, vecAddr}, {1'b1, m, a});
      if (m) chk(vecNum, (a - B1) >> 2);
      repeat (3) @(posedge clk_sys);
    end
  endtask
  task fire(input [43:0] v);
    begin
      @(posedge clk_sys);
      pulses <= v;
      @(posedge clk_sys);
      pulses <= 44'h0;
    end
  endtask
  task nov;
    begin
      k = 0;
      repeat (6) begin
        @(posedge clk_sys);
        if (vecValid !== 1'b0) k = 1;
      end
      chk(k, 0);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // ==========================================
  // tests
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pulses, softIntNum} = 0;
    {resetn, ackDelay, breakFixedByte, nmiPinN, n_fail, check_count} = {5'h0, 8'h0, 1'b1, 64'h0};
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    expv(20'hFFFFC, 1'b0);
    rdc(`IVR_IDX_FLAG, 32'h0);
    apb(12'h001, 1'b0, 32'h0);
    chk({pslverr, q}, {1'b1, 32'h0});
    apb(`IVR_IDX_BASE, 1'b1, B1);
    apb(`IVR_IDX_FLAG, 1'b1, 32'h21);
    $display("test reset and setup done");
    for (n = 1; n < 32; n = n + 1) begin
      if (n != 8 && n != 9 && n != 15 && n != 16) begin
        ackDelay <= n[3:0];
        apb(`IVR_IDX_CTRL0 + n[11:0], 1'b1, 32'h3);
        fire(44'h1 << (12 + n));
        expv(B1 + {n[17:0], 2'b00}, 1'b1);
        rdc(`IVR_IDX_CTRL0 + n[11:0], 32'h3);
      end
    end
    apb(`IVR_IDX_CAUSE, 1'b1, 32'h0);
    for (n = 8; n < 17; n = n + 1) apb(`IVR_IDX_CTRL0 + n[11:0], 1'b1, 32'h3);
    fire(44'h1 << 20);
    nov;
    fire(44'h100);
    expv(B1 + 20'd32, 1'b1);
    fire(44'h200);
    expv(B1 + 20'd36, 1'b1);
    apb(`IVR_IDX_CAUSE, 1'b1, 32'hC0);
    fire(44'h1 << 20);
    expv(B1 + 20'd32, 1'b1);
    fire(44'h1 << 21);
    expv(B1 + 20'd36, 1'b1);
    fire(44'h1 << 27);
    expv(B1 + 20'd60, 1'b1);
    apb(`IVR_IDX_DCFG, 1'b1, 32'h2);
    fire(44'h400);
    expv(B1 + 20'd60, 1'b1);
    fire(44'h800);
    expv(B1 + 20'd64, 1'b1);
    fire(44'h1 << 28);
    nov;
    $display("test slot map done");
    apb(`IVR_IDX_CTRL0 + 12'd22, 1'b1, 32'h2);
    fire(44'h1 << 34);
    nov;
    rdc(`IVR_IDX_CTRL0 + 12'd22, 32'hA);
    apb(`IVR_IDX_CTRL0 + 12'd22, 1'b1, 32'h2);
    rdc(`IVR_IDX_CTRL0 + 12'd22, 32'h2);
    apb(`IVR_IDX_CTRL0 + 12'd22, 1'b1, 32'hA);
    rdc(`IVR_IDX_CTRL0 + 12'd22, 32'h2);
    apb(`IVR_IDX_FLAG, 1'b1, 32'h20);
    apb(`IVR_IDX_CTRL0 + 12'd23, 1'b1, 32'h7);
    fire(44'h1 << 35);
    nov;
    apb(`IVR_IDX_FLAG, 1'b1, 32'h21);
    expv(B1 + 20'd92, 1'b1);
    $display("test gating done");
    apb(`IVR_IDX_FLAG, 1'b1, 32'h0);
    apb(`IVR_IDX_DCFG, 1'b1, 32'h0);
    fire(44'h1);
    expv(20'hFFFDC, 1'b0);
    fire(44'h2);
    expv(20'hFFFE0, 1'b0);
    fire(44'h8);
    expv(20'hFFFF0, 1'b0);
    fire(44'h20);
    expv(20'hFFFEC, 1'b0);
    fire(44'h40);
    expv(20'hFFFF4, 1'b0);
    fire(44'h10);
    nov;
    apb(`IVR_IDX_DCFG, 1'b1, 32'h1);
    fire(44'h10);
    expv(20'hFFFE8, 1'b0);
    fire(44'h4);
    expv(20'hFFFE4, 1'b0);
    apb(`IVR_IDX_BASE, 1'b1, B2);
    rdc(`IVR_IDX_BASE, B2);
    breakFixedByte <= 8'hFF;
    fire(44'h4);
    expv(B2, 1'b0);
    softIntNum <= 6'h3F;
    fire(44'h80);
    expv(B2 + 20'd252, 1'b0);
    nmiPinN <= 1'b0;
    expv(20'hFFFF8, 1'b0);
    nmiPinN <= 1'b1;
    $display("test fixed vectors done");
    give_verdict;
  end
  initial begin
    #200000;
    n_fail = n_fail + 1;
    give_verdict;
  end
endmodule
